// *** ppd_port.sv ***
// Eight-pin I/O port: drive modes, pin state, edge interrupts, special I/O controls
//
// Local design decisions: register access over APB and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
`include "ppd_regs.svh"

module ppd_port
    import ppd_pkg::*;
(
    input  wire logic        pclk,          // Bus clock
    input  wire logic        presetn,       // Async reset, active low
    input  wire logic [11:0] paddr,         // APB address
    input  wire logic        psel,          // APB select
    input  wire logic        penable,       // APB access phase
    input  wire logic        pwrite,        // APB direction
    input  wire logic [31:0] pwdata,        // APB write data
    output logic      [31:0] prdata,        // APB read data
    output logic             pready,        // APB ready
    output logic             pslverr,       // APB error on unmapped address
    input  wire logic        low_power,     // Device in a low power mode
    input  wire logic [7:0]  pad_in,        // Pin levels
    output logic      [7:0]  pad_o,         // Level driven on each pin
    output logic      [7:0]  pad_oe,        // Strong driver on
    output logic      [7:0]  pad_pu,        // Resistive pull-up on
    output logic      [7:0]  pad_pd,        // Resistive pull-down on
    output logic      [7:0]  pad_ie,        // Digital input buffer on
    input  wire logic [7:0]  route_out,     // Routing array signals for bypass
    output logic      [7:0]  route_in,      // Pin inputs to peripherals
    output logic      [7:0]  sio_reg_sel,   // Regulated high output select
    output logic      [7:0]  sio_hyst_en,   // Input hysteresis enable
    output logic      [7:0]  sio_thresh,    // Two bits per pin pair
    output logic             port_irq       // Port interrupt request
);

    ppd_state_s st;
    ppd_state_s next_st;
    logic       setup_ph;
    logic       access_ph;
    logic [7:0] edges;
    logic [7:0] drive_val;

    // Drive decode: returns {o, oe, pu, pd, ie}
    function automatic logic [4:0] drive_decode(input ppd_code_t code, input logic v,
                                                 input logic regulated);
        logic [4:0] r;
        r = 5'h00;
        case (code)
            3'h0: r = 5'h00;
            3'h1: r = 5'h01;
            3'h2: r = v ? 5'h15 : 5'h09;
            3'h3: r = v ? 5'h19 : 5'h03;
            3'h4: r = v ? 5'h01 : 5'h09;
            3'h5: r = v ? 5'h19 : 5'h01;
            3'h6: r = v ? 5'h19 : 5'h09;
            3'h7: r = v ? 5'h15 : 5'h03;
            default: r = 5'h00;
        endcase
        // Pulls are unavailable on a regulated output
        if (regulated) begin
            r[2] = 1'b0;
            r[1] = 1'b0;
        end
        return r;
    endfunction

    function automatic ppd_code_t pin_code(input ppd_state_s s, input int i);
        return {s.dm2[i], s.dm1[i], s.dm0[i]};
    endfunction

    function automatic logic [7:0] dm_eq(input ppd_state_s s, input ppd_code_t c);
        logic [7:0] m;
        m = 8'h00;
        for (int i = 0; i < 8; i++) begin
            m[i] = (pin_code(s, i) == c);
        end
        return m;
    endfunction

    function automatic logic is_pin(input logic [11:0] a);
        return (a & `PPD_PIN_MASK) == `PPD_OFS_PIN0;
    endfunction

    function automatic logic addr_ok(input logic [11:0] a);
        logic ok;
        ok = is_pin(a);
        case (a)
            `PPD_OFS_DATA, `PPD_OFS_PINS, `PPD_OFS_DM0, `PPD_OFS_DM1, `PPD_OFS_DM2,
            `PPD_OFS_BYPASS, `PPD_OFS_RISE, `PPD_OFS_FALL, `PPD_OFS_ISTS,
            `PPD_OFS_REGSEL, `PPD_OFS_HYST, `PPD_OFS_THRESH: ok = 1'b1;
            default: ok = ok;
        endcase
        return ok;
    endfunction

    function automatic logic [31:0] reg_read(input logic [11:0] a, input ppd_state_s s);
        logic [31:0] d;
        int          i;
        d = 32'h0000_0000;
        i = int'(a[4:2]);
        if (is_pin(a)) begin
            d[`PPD_PF_DM_LO +: 3] = pin_code(s, i);
            d[`PPD_PF_DR]   = s.dr[i];
            d[`PPD_PF_BYP]  = s.bypass[i];
            d[`PPD_PF_RISE] = s.rise[i];
            d[`PPD_PF_FALL] = s.fall[i];
            d[`PPD_PF_PS]   = s.pin_in[i];
            d[`PPD_PF_REG]  = s.regsel[i];
            d[`PPD_PF_HYST] = s.hyst[i];
        end
        case (a)
            `PPD_OFS_DATA:   d[7:0] = s.dr;
            `PPD_OFS_PINS:   d[7:0] = s.pin_in;
            `PPD_OFS_DM0:    d[7:0] = s.dm0;
            `PPD_OFS_DM1:    d[7:0] = s.dm1;
            `PPD_OFS_DM2:    d[7:0] = s.dm2;
            `PPD_OFS_BYPASS: d[7:0] = s.bypass;
            `PPD_OFS_RISE:   d[7:0] = s.rise;
            `PPD_OFS_FALL:   d[7:0] = s.fall;
            `PPD_OFS_ISTS:   d[7:0] = s.ists;
            `PPD_OFS_REGSEL: d[7:0] = s.regsel;
            `PPD_OFS_HYST:   d[7:0] = s.hyst;
            `PPD_OFS_THRESH: d[7:0] = s.thresh;
            default:         d = d;
        endcase
        return d;
    endfunction

    assign setup_ph  = psel & ~penable;
    assign access_ph = psel & penable;
    assign pready    = 1'b1;
    assign pslverr   = access_ph & ~addr_ok(paddr);

    // Pins held while the routing array sleeps keep their last routed value
    assign drive_val = (st.bypass & st.route_hold) | (~st.bypass & st.dr);
    assign edges     = (st.pin_in & ~st.prev_in & st.rise)
                     | (~st.pin_in & st.prev_in & st.fall);

    always_comb begin
        logic [4:0] dec;
        int         pi;
        dec     = 5'h00;
        pi      = int'(paddr[4:2]);
        next_st = st;
        // Read data is captured in the setup phase so it leaves a flop
        if (setup_ph) begin
            next_st.rdata = reg_read(paddr, st);
        end
        if (access_ph && pwrite) begin
            case (paddr)
                `PPD_OFS_DATA:   next_st.dr     = pwdata[7:0];
                `PPD_OFS_DM0:    next_st.dm0    = pwdata[7:0];
                `PPD_OFS_DM1:    next_st.dm1    = pwdata[7:0];
                `PPD_OFS_DM2:    next_st.dm2    = pwdata[7:0];
                `PPD_OFS_BYPASS: next_st.bypass = pwdata[7:0];
                `PPD_OFS_RISE:   next_st.rise   = pwdata[7:0];
                `PPD_OFS_FALL:   next_st.fall   = pwdata[7:0];
                `PPD_OFS_REGSEL: next_st.regsel = pwdata[7:0];
                `PPD_OFS_HYST:   next_st.hyst   = pwdata[7:0];
                `PPD_OFS_THRESH: next_st.thresh = pwdata[7:0];
                default:         next_st.dr     = next_st.dr;
            endcase
            if (is_pin(paddr)) begin
                next_st.dm0[pi]    = pwdata[`PPD_PF_DM_LO];
                next_st.dm1[pi]    = pwdata[`PPD_PF_DM_LO + 1];
                next_st.dm2[pi]    = pwdata[`PPD_PF_DM_LO + 2];
                next_st.dr[pi]     = pwdata[`PPD_PF_DR];
                next_st.bypass[pi] = pwdata[`PPD_PF_BYP];
                next_st.rise[pi]   = pwdata[`PPD_PF_RISE];
                next_st.fall[pi]   = pwdata[`PPD_PF_FALL];
                next_st.regsel[pi] = pwdata[`PPD_PF_REG];
                next_st.hyst[pi]   = pwdata[`PPD_PF_HYST];
            end
        end
        // Only the flags the read returned are cleared; later edges survive
        if (access_ph && !pwrite && paddr == `PPD_OFS_ISTS) begin
            next_st.ists = st.ists & ~st.rdata[7:0];
        end
        next_st.ists    = next_st.ists | edges;
        next_st.prev_in = st.pin_in;
        next_st.pin_in  = pad_in & st.pad.ie;
        if (!low_power) begin
            next_st.route_hold = route_out;
        end
        for (int i = 0; i < 8; i++) begin
            dec = drive_decode(pin_code(st, i), drive_val[i], st.regsel[i]);
            next_st.pad.o[i]  = dec[4];
            next_st.pad.oe[i] = dec[3];
            next_st.pad.pu[i] = dec[2];
            next_st.pad.pd[i] = dec[1];
            next_st.pad.ie[i] = dec[0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st        <= '0;
            st.dm0    <= `PPD_RST_DM;
            st.dm1    <= `PPD_RST_DM;
            st.dm2    <= `PPD_RST_DM;
            st.dr     <= `PPD_RST_BYTE;
            st.thresh <= `PPD_RST_BYTE;
        end else begin
            st <= next_st;
        end
    end

    assign prdata      = st.rdata;
    assign pad_o       = st.pad.o;
    assign pad_oe      = st.pad.oe;
    assign pad_pu      = st.pad.pu;
    assign pad_pd      = st.pad.pd;
    assign pad_ie      = st.pad.ie;
    assign route_in    = st.pin_in;
    assign sio_reg_sel = st.regsel;
    assign sio_hyst_en = st.hyst;
    assign sio_thresh  = st.thresh;
    assign port_irq    = |st.ists;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_mode_off: assert property (
        (($past(dm_eq(st, 3'h0)) & (pad_ie | pad_oe | pad_pu | pad_pd)) == 8'h00))
        else $error("analog mode pin not fully off");

    a_mode_input: assert property (
        (($past(dm_eq(st, 3'h1)) & (~pad_ie | pad_oe | pad_pu | pad_pd)) == 8'h00))
        else $error("digital high-z pin drives or lacks input");

    a_strong_drive: assert property (
        (($past(dm_eq(st, 3'h6)) & (~pad_oe | (pad_o ^ $past(drive_val)))) == 8'h00))
        else $error("strong mode pin does not follow data");

    a_open_low: assert property (
        (($past(dm_eq(st, 3'h4)) & ((pad_oe & pad_o) | (~pad_oe & ~$past(drive_val))))
         == 8'h00))
        else $error("open drain low mode drives wrong level");

    a_reg_nopull: assert property (
        ((pad_pu | pad_pd) & $past(st.regsel)) == 8'h00)
        else $error("pull active on regulated pin");

    a_edge_irq: assert property (
        (|edges) |=> port_irq)
        else $error("enabled edge raised no request");

    a_read_clear: assert property (
        (access_ph && !pwrite && paddr == `PPD_OFS_ISTS && edges == 8'h00)
        |=> ((st.ists & $past(st.rdata[7:0])) == 8'h00))
        else $error("status read did not clear flags");

    a_reset_mode: assert property (
        $rose(presetn) |-> (pad_ie == 8'h00 && pad_oe == 8'h00 && st.dm2 == 8'h00))
        else $error("pins not in analog mode after reset");

    a_pin_read: assert property (
        ##1 st.pin_in == $past(pad_in & pad_ie))
        else $error("pin state register wrong");

    a_lp_hold: assert property (
        (low_power && $past(low_power) && !$past(psel, 2) && !$past(psel))
        |-> $stable(st.pad))
        else $error("pin state changed in low power");

    a_pull_up_mode: assert property (
        (($past(dm_eq(st, 3'h2) & ~st.regsel) & ((pad_oe ^ ~$past(drive_val))
         | (pad_pu ^ $past(drive_val)) | (pad_oe & pad_o) | ~pad_ie)) == 8'h00))
        else $error("pull-up mode pin drives wrong level");

    a_pull_down_mode: assert property (
        (($past(dm_eq(st, 3'h3) & ~st.regsel) & ((pad_oe ^ $past(drive_val))
         | (pad_pd ^ ~$past(drive_val)) | (pad_oe & ~pad_o) | ~pad_ie)) == 8'h00))
        else $error("pull-down mode pin drives wrong level");

    a_open_high: assert property (
        (($past(dm_eq(st, 3'h5)) & ((pad_oe ^ $past(drive_val)) | (pad_oe & ~pad_o)
         | pad_pu | pad_pd)) == 8'h00))
        else $error("open drain high mode drives wrong level");

    a_route_sample: assert property (
        !$past(low_power) |-> (st.route_hold == $past(route_out)))
        else $error("routed drive value not sampled");

    a_route_freeze: assert property (
        $past(low_power) |-> $stable(st.route_hold))
        else $error("routed drive value changed in low power");

    a_flag_sticky: assert property (
        !$past(access_ph && !pwrite && paddr == `PPD_OFS_ISTS)
        |-> ((st.ists & $past(st.ists)) == $past(st.ists)))
        else $error("pending flag lost without status read");

    // Loose on purpose: only demands that the pin moved with an edge enabled,
    // so it stays independent of the exact edge expression above
    a_flag_source: assert property (
        ((st.ists & ~$past(st.ists)
          & ~$past((st.pin_in ^ st.prev_in) & (st.rise | st.fall))) == 8'h00))
        else $error("pending flag set without enabled edge");

    a_pins_ro: assert property (
        (access_ph && pwrite && paddr == `PPD_OFS_PINS) |=> (st.dr == $past(st.dr)))
        else $error("write to pin state register changed output data");

    a_pin_code_view: assert property (
        (access_ph && pwrite && is_pin(paddr))
        |=> (pin_code(st, int'($past(paddr[4:2]))) == $past(pwdata[2:0])))
        else $error("per-pin code write not seen in port registers");

    a_pin_hyst_view: assert property (
        (access_ph && pwrite && is_pin(paddr))
        |=> (sio_hyst_en[$past(paddr[4:2])] == $past(pwdata[`PPD_PF_HYST])))
        else $error("per-pin hysteresis write not seen");

    a_thresh_write: assert property (
        (access_ph && pwrite && paddr == `PPD_OFS_THRESH)
        |=> (sio_thresh == $past(pwdata[7:0])))
        else $error("threshold write not applied");

    c_edge_irq:   cover property (|edges ##1 port_irq ##[1:20] !port_irq);
    c_pin_write:  cover property (access_ph && pwrite && is_pin(paddr));
    c_bypass_drv: cover property (|(st.bypass & dm_eq(st, 3'h6)));
    c_low_power:  cover property (low_power ##1 low_power);
    c_ists_read:  cover property (access_ph && !pwrite && paddr == `PPD_OFS_ISTS && port_irq);

endmodule
`default_nettype wire

// *** ppd_regs.svh ***
// Register offsets, reset values and field positions of the port pin drive block
`ifndef PPD_REGS_SVH
`define PPD_REGS_SVH

`define PPD_OFS_DATA    12'h000
`define PPD_OFS_PINS    12'h004
`define PPD_OFS_DM0     12'h008
`define PPD_OFS_DM1     12'h00C
`define PPD_OFS_DM2     12'h010
`define PPD_OFS_BYPASS  12'h014
`define PPD_OFS_RISE    12'h018
`define PPD_OFS_FALL    12'h01C
`define PPD_OFS_ISTS    12'h020
`define PPD_OFS_REGSEL  12'h024
`define PPD_OFS_HYST    12'h028
`define PPD_OFS_THRESH  12'h02C
`define PPD_OFS_PIN0    12'h040
`define PPD_PIN_MASK    12'hFE3

`define PPD_RST_DM      8'h00
`define PPD_RST_BYTE    8'h00

`define PPD_PF_DM_LO    0
`define PPD_PF_DR       3
`define PPD_PF_BYP      4
`define PPD_PF_RISE     5
`define PPD_PF_FALL     6
`define PPD_PF_PS       7
`define PPD_PF_REG      8
`define PPD_PF_HYST     9

`endif

// *** ppd_pkg.sv ***
// Types shared by the port pin drive block
package ppd_pkg;

    typedef logic [2:0] ppd_code_t;

    typedef struct packed {
        logic [7:0] o;
        logic [7:0] oe;
        logic [7:0] pu;
        logic [7:0] pd;
        logic [7:0] ie;
    } ppd_pad_s;

    typedef struct packed {
        logic [7:0]  dr;
        logic [7:0]  bypass;
        logic [7:0]  dm0;
        logic [7:0]  dm1;
        logic [7:0]  dm2;
        logic [7:0]  rise;
        logic [7:0]  fall;
        logic [7:0]  ists;
        logic [7:0]  regsel;
        logic [7:0]  hyst;
        logic [7:0]  thresh;
        logic [7:0]  pin_in;
        logic [7:0]  prev_in;
        logic [7:0]  route_hold;
        logic [31:0] rdata;
        ppd_pad_s    pad;
    } ppd_state_s;

endpackage

// *** ppd_pin_model.sv ***
// External circuit model that resolves the level seen on each port pin
`timescale 1ns/1ns
`default_nettype none
module ppd_pin_model (
    input  wire logic       clk,      // Bench clock
    input  wire logic [7:0] pad_o,    // Level the port drives
    input  wire logic [7:0] pad_oe,   // Strong driver on
    input  wire logic [7:0] pad_pu,   // Pull-up on
    input  wire logic [7:0] pad_pd,   // Pull-down on
    input  wire logic [7:0] ext_en,   // External driver on
    input  wire logic [7:0] ext_val,  // External driver level
    output logic      [7:0] pad_in    // Resolved pin level
);
    logic [7:0] last = 8'h00;

    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (ext_en[i]) pad_in[i] = ext_val[i];
            else if (pad_oe[i]) pad_in[i] = pad_o[i];
            else if (pad_pu[i]) pad_in[i] = 1'b1;
            else if (pad_pd[i]) pad_in[i] = 1'b0;
            // A floating pin must not read as a steady level
            else pad_in[i] = ~last[i];
        end
    end

    always_ff @(posedge clk) last <= pad_in;
endmodule
`default_nettype wire

// *** ppd_port_tb.sv ***
// Self-checking testbench of the port pin drive block
`timescale 1ns/1ns
`default_nettype none
`include "ppd_regs.svh"
module ppd_port_tb;
    import ppd_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, low_power = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, port_irq, err;
    logic [7:0] pad_in, pad_o, pad_oe, pad_pu, pad_pd, pad_ie, route_in;
    logic [7:0] sio_reg_sel, sio_hyst_en, sio_thresh;
    logic [7:0] route_out = 8'h00, ext_en = 8'h00, ext_val = 8'h00;
    int miscompares = 0, n_compared = 0;

    always #50 pclk = ~pclk;

    ppd_port i_ppd_port (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .low_power(low_power), .pad_in(pad_in),
        .pad_o(pad_o), .pad_oe(pad_oe), .pad_pu(pad_pu), .pad_pd(pad_pd), .pad_ie(pad_ie),
        .route_out(route_out), .route_in(route_in), .sio_reg_sel(sio_reg_sel),
        .sio_hyst_en(sio_hyst_en), .sio_thresh(sio_thresh), .port_irq(port_irq));

    ppd_pin_model i_ppd_pin_model (.clk(pclk), .pad_o(pad_o), .pad_oe(pad_oe),
        .pad_pu(pad_pu), .pad_pd(pad_pd), .ext_en(ext_en), .ext_val(ext_val),
        .pad_in(pad_in));

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic final_report();
        if (miscompares == 0 && n_compared > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    // Read data and error are taken only at the edge that sees pready high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    // Outputs are read at the edge, before it updates them, after two settled cycles
    task automatic settle();
        repeat (3) @(posedge pclk);
    endtask

    // Expected {oe, o, pu, pd, ie} of a pin for a code and data bit
    function automatic logic [4:0] exp_pad(input logic [2:0] c, input logic d);
        case (c)
            3'h0: return 5'h00;
            3'h1: return 5'h01;
            3'h2: return d ? 5'h05 : 5'h11;
            3'h3: return d ? 5'h19 : 5'h03;
            3'h4: return d ? 5'h01 : 5'h11;
            3'h5: return d ? 5'h19 : 5'h01;
            3'h6: return d ? 5'h19 : 5'h11;
            default: return d ? 5'h05 : 5'h03;
        endcase
    endfunction

    task automatic t_reset();
        chk("pads", {pad_oe, pad_pu, pad_pd, pad_ie}, 32'h0);
        chk("irq", port_irq, 1'b0);
        apb(1'b0, `PPD_OFS_DM0, 32'h0);
        chk("dm0", rd, 32'h0);
    endtask

    task automatic t_modes();
        logic [4:0] s;
        for (int k = 0; k < 16; k++) begin
            apb(1'b1, `PPD_OFS_PIN0, 32'(k));
            settle();
            s = {pad_oe[0], pad_o[0] & pad_oe[0], pad_pu[0], pad_pd[0], pad_ie[0]};
            chk("mode", s, exp_pad(k[2:0], k[3]));
            if (k[2:0] inside {3'h0, 3'h1, 3'h4} || k[3:0] == 4'h3) begin
                chk("tolerant", {pad_oe[0] & pad_o[0], pad_pu[0]}, 2'h0);
            end
        end
    endtask

    task automatic t_pins();
        apb(1'b1, `PPD_OFS_DM0, 32'hFF);
        apb(1'b1, `PPD_OFS_DM1, 32'h00);
        apb(1'b1, `PPD_OFS_DM2, 32'h00);
        apb(1'b0, `PPD_OFS_PIN0 + 12'h004, 32'h0);
        chk("pin view", rd[2:0], 3'h1);
        ext_en <= 8'hFF;
        ext_val <= 8'hA5;
        apb(1'b1, `PPD_OFS_DATA, 32'h3C);
        settle();
        chk("route_in", route_in, 8'hA5);
        apb(1'b0, `PPD_OFS_PINS, 32'h0);
        chk("pins", rd, 32'hA5);
        apb(1'b1, `PPD_OFS_PINS, 32'hFF);
        apb(1'b0, `PPD_OFS_DATA, 32'h0);
        chk("data", rd, 32'h3C);
        apb(1'b1, `PPD_OFS_PIN0, 32'h0);
        settle();
        apb(1'b0, `PPD_OFS_PINS, 32'h0);
        chk("no input", rd[0], 1'b0);
    endtask

    task automatic t_irq();
        apb(1'b1, `PPD_OFS_RISE, 32'h02);
        apb(1'b0, `PPD_OFS_ISTS, 32'h0);
        ext_val <= 8'h00;
        settle();
        chk("no rise", port_irq, 1'b0);
        ext_val <= 8'h02;
        settle();
        chk("rise irq", port_irq, 1'b1);
        apb(1'b0, `PPD_OFS_ISTS, 32'h0);
        chk("ists", rd, 32'h02);
        settle();
        chk("cleared", port_irq, 1'b0);
        apb(1'b1, `PPD_OFS_RISE, 32'h00);
        apb(1'b1, `PPD_OFS_FALL, 32'h82);
        ext_val <= 8'h80;
        settle();
        chk("fall", port_irq, 1'b1);
        apb(1'b0, `PPD_OFS_ISTS, 32'h0);
        chk("fall ists", rd, 32'h02);
    endtask

    task automatic t_bypass_sleep();
        ext_en <= 8'h00;
        route_out <= 8'h04;
        apb(1'b1, `PPD_OFS_PIN0 + 12'h008, 32'h16);
        settle();
        chk("bypass hi", {pad_oe[2], pad_o[2]}, 2'h3);
        low_power <= 1'b1;
        route_out <= 8'h00;
        settle();
        chk("sleep hold", {pad_oe[2], pad_o[2]}, 2'h3);
        low_power <= 1'b0;
        settle();
        chk("wake", {pad_oe[2], pad_o[2]}, 2'h2);
    endtask

    task automatic t_sio();
        apb(1'b1, `PPD_OFS_PIN0 + 12'h00C, 32'h10A);
        apb(1'b1, `PPD_OFS_HYST, 32'hA5);
        apb(1'b1, `PPD_OFS_THRESH, 32'hE4);
        settle();
        chk("regsel", sio_reg_sel, 8'h08);
        chk("no pull", pad_pu[3], 1'b0);
        chk("hyst", sio_hyst_en, 8'hA5);
        chk("thresh", sio_thresh, 8'hE4);
        apb(1'b0, `PPD_OFS_REGSEL, 32'h0);
        chk("regsel view", rd, 32'h08);
        apb(1'b0, 12'h030, 32'h0);
        chk("unmapped err", err, 1'b1);
        chk("unmapped data", rd, 32'h0);
    endtask

    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset();
        t_modes();
        t_pins();
        t_irq();
        t_bypass_sleep();
        t_sio();
        final_report();
    end

    // The run needs well under 2000 cycles
    initial begin
        repeat (20000) @(posedge pclk);
        miscompares++;
        final_report();
    end
endmodule
`default_nettype wire
